/* pkg/ramp_seq_pkg.sv */
// Constants and carrier types for the output ramp sequencer.
// Assumes a 125 MHz system clock and a shared timing clock sampled as a plain input.
package ramp_seq_pkg;
	localparam int CLK_MHZ = 125;
	// Step interval of the rise ramp, in microseconds
	localparam int STEP_US = 100;
	// Soft start is skipped below this rise time, in microseconds
	localparam int MIN_RISE_US = 250;
	// Longest rise time allowed, in microseconds
	localparam int MAX_RISE_US = 1300000;
	// Power-good glitch filter, in microseconds
	localparam int PG_FILTER_US = 100;
	// Servo step interval, in milliseconds
	localparam int SERVO_MS = 100;
	localparam int PG_FILTER_CYC = PG_FILTER_US * CLK_MHZ;
	localparam int SERVO_CYC = SERVO_MS * 1000 * CLK_MHZ;
	localparam int MIN_RISE_STEPS = (MIN_RISE_US + STEP_US - 1) / STEP_US;
	localparam int MAX_RISE_STEPS = MAX_RISE_US / STEP_US;
	// Mode configuration bit positions
	localparam int MODE_CONT_BIT = 0;
	localparam int MODE_SERVO_BIT = 6;
	localparam logic [7:0] RESP_IGNORE = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;

	typedef enum {ST_HOLD, ST_DELAY, ST_RISE, ST_WAIT_MAX, ST_RUN} seq_state_t;

	typedef struct packed {
		logic [15:0] turn_on_delay_setting;   // Shared-clock ticks
		logic [15:0] turn_on_rise_time;       // Units of the step interval
		logic [15:0] max_turn_on_time_limit;  // Shared-clock ticks, zero is infinite
		logic [7:0] max_turn_on_time_response;
		logic [7:0] switching_mode_config;
	} seq_cfg_t;

	typedef struct packed {
		logic init_done;
		logic input_above_on;
		logic output_above_uv;
		logic output_undervoltage_fault;
		logic output_overcurrent_fault;
		logic reverse_current;
		logic pg_raw;
	} seq_sense_t;
endpackage : ramp_seq_pkg

/* core/glitch_filter.sv */
// Holds a level until the input has been stable for FILTER_CYC cycles.
// Assumes the input is synchronous to clk_sys.
`timescale 1ns/100ps
module glitch_filter #(
	parameter int FILTER_CYC = 12500
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Data
	input wire logic din,
	output logic dout
);
	logic [23:0] cnt;
	logic [23:0] next_cnt;
	logic next_dout;

	always_comb begin
		next_cnt = 24'h000000;
		next_dout = dout;
		if (din != dout) begin
			if (cnt >= 24'(FILTER_CYC - 1)) begin
				next_dout = din;
			end else begin
				next_cnt = cnt + 24'h000001;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cnt <= 24'h000000;
			dout <= 1'b0;
		end else begin
			cnt <= next_cnt;
			dout <= next_dout;
		end
	end
endmodule : glitch_filter

/* core/output_ramp_sequencer.sv */
// Start-up sequencer for one output channel: run line, delay, digital rise ramp, servo.
// Assumes synchronous inputs, a shared timing clock sampled on clk_sys, and an
// external DAC and ADC path whose codes appear on the ports below.
//
// Contract
// - Hold run pin low until own init done and input above on-threshold.
// - Shared run line stays low until every device is ready.
// - After run line is released, wait the turn-on delay before ramping.
// - All devices time delays from the one shared timing clock.
// - Soft start steps target from zero up to the setpoint.
// - Rise time below a quarter millisecond skips the ramp.
// - One target step every tenth millisecond; steps equal rise time over interval.
// - Force discontinuous switching throughout the rise ramp.
// - In discontinuous mode cut bottom gate on reverse current.
// - Power-good output is filtered against short glitches.
// - Servo runs only when mode bit six is set.
// - Servo moves DAC one step every 100 ms toward the ADC target.
// - Servo starts after max turn-on time, or after ramp and UV exceeded if zero.
// - Switch to programmed mode bit zero when servo may begin.
// - Ignore response: ramp done, limit reached, above UV or overcurrent clear.
// - Other response: ramp done, limit expired, no UV and no OC fault.
// - Rise time is limited to 1.3 seconds.
`timescale 1ns/100ps
module output_ramp_sequencer
	import ramp_seq_pkg::*;
#(
	parameter int DAC_W = 12,
	parameter int SERVO_CYCLES = SERVO_CYC,
	parameter int PG_CYCLES = PG_FILTER_CYC,
	// Shared-clock ticks per ramp step
	parameter int TICKS_PER_STEP = 10
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Configuration and analog status
	input wire seq_cfg_t cfg,
	input wire seq_sense_t sense,
	input wire logic [DAC_W-1:0] setpoint,
	input wire logic [DAC_W-1:0] adc_reading,
	// Shared lines
	input wire logic share_clk,
	input wire logic output_run_pin_in,
	output logic output_run_pin_out,
	output logic output_run_pin_oe,
	// Power stage and status
	output logic [DAC_W-1:0] dac_code,
	output logic discontinuous,
	output logic bottom_gate_en,
	output logic servo_active,
	output logic power_good_pin,
	output logic ramping
);
	seq_state_t state, next_state;
	logic [15:0] tick_cnt, next_tick_cnt;
	logic [15:0] step_cnt, next_step_cnt;
	logic [15:0] steps, rise_lim;
	logic [DAC_W-1:0] next_dac_code;
	logic [26:0] servo_cnt, next_servo_cnt;
	logic share_q;
	logic tick;
	logic limit_ok;
	logic next_oe, next_disc, next_bottom, next_servo, next_ramping;
	logic pg_filt;

	// Shared clock edges time every delay and ramp step
	assign tick = share_clk && !share_q;
	// Rise time clipped to the longest allowed value
	assign rise_lim = (cfg.turn_on_rise_time > 16'(MAX_RISE_STEPS)) ?
		16'(MAX_RISE_STEPS) : cfg.turn_on_rise_time;
	assign steps = rise_lim;

	always_comb begin
		if (cfg.max_turn_on_time_response == RESP_IGNORE) begin
			limit_ok = sense.output_above_uv || !sense.output_overcurrent_fault;
		end else begin
			limit_ok = !sense.output_undervoltage_fault && !sense.output_overcurrent_fault;
		end
	end

	always_comb begin
		next_state = state;
		next_tick_cnt = tick_cnt;
		next_step_cnt = step_cnt;
		next_dac_code = dac_code;
		next_servo_cnt = servo_cnt;
		next_oe = 1'b1;
		next_disc = 1'b1;
		next_servo = 1'b0;
		next_ramping = 1'b0;
		case (state)
			ST_HOLD: begin
				next_dac_code = '0;
				next_tick_cnt = 16'h0000;
				// Own drive lets go only when this device is ready
				if (sense.init_done && sense.input_above_on) begin
					next_oe = 1'b0;
					// Others may still pull the line low
					if (output_run_pin_in) begin
						next_state = ST_DELAY;
					end
				end
			end
			ST_DELAY: begin
				next_oe = 1'b0;
				if (tick_cnt >= cfg.turn_on_delay_setting) begin
					next_tick_cnt = 16'h0000;
					next_step_cnt = 16'h0000;
					if (steps < 16'(MIN_RISE_STEPS)) begin
						next_dac_code = setpoint;
						next_state = ST_WAIT_MAX;
					end else begin
						next_state = ST_RISE;
					end
				end else if (tick) begin
					next_tick_cnt = tick_cnt + 16'h0001;
				end
			end
			ST_RISE: begin
				next_oe = 1'b0;
				next_ramping = 1'b1;
				if (tick) begin
					if (tick_cnt >= 16'(TICKS_PER_STEP - 1)) begin
						next_tick_cnt = 16'h0000;
						next_step_cnt = step_cnt + 16'h0001;
						// Linear fraction of setpoint; wide product avoids overflow
						next_dac_code = DAC_W'((32'(setpoint) * 32'(step_cnt + 16'h0001)) / 32'(steps));
						if (step_cnt + 16'h0001 >= steps) begin
							next_dac_code = setpoint;
							next_state = ST_WAIT_MAX;
						end
					end else begin
						next_tick_cnt = tick_cnt + 16'h0001;
					end
				end
			end
			ST_WAIT_MAX: begin
				next_oe = 1'b0;
				if (cfg.max_turn_on_time_limit == 16'h0000) begin
					if (sense.output_above_uv) begin
						next_state = ST_RUN;
					end
				end else if (tick_cnt >= cfg.max_turn_on_time_limit) begin
					if (limit_ok) begin
						next_state = ST_RUN;
					end
				end else if (tick) begin
					next_tick_cnt = tick_cnt + 16'h0001;
				end
				next_servo_cnt = 27'h0000000;
			end
			ST_RUN: begin
				next_oe = 1'b0;
				next_disc = !cfg.switching_mode_config[MODE_CONT_BIT];
				next_servo = cfg.switching_mode_config[MODE_SERVO_BIT];
				if (!cfg.switching_mode_config[MODE_SERVO_BIT]) begin
					next_dac_code = setpoint;
					next_servo_cnt = 27'h0000000;
				end else if (servo_cnt >= 27'(SERVO_CYCLES - 1)) begin
					next_servo_cnt = 27'h0000000;
					// One code step per interval toward the target reading
					if (adc_reading < setpoint && dac_code != '1) begin
						next_dac_code = dac_code + DAC_W'(1);
					end else if (adc_reading > setpoint && dac_code != '0) begin
						next_dac_code = dac_code - DAC_W'(1);
					end
				end else begin
					next_servo_cnt = servo_cnt + 27'h0000001;
				end
			end
			default: next_state = ST_HOLD;
		endcase
		// Losing input or init restarts the whole sequence
		if (!sense.init_done || !sense.input_above_on) begin
			next_state = ST_HOLD;
			next_oe = 1'b1;
		end
		next_bottom = !(next_disc && sense.reverse_current);
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state <= ST_HOLD;
			tick_cnt <= 16'h0000;
			step_cnt <= 16'h0000;
			dac_code <= '0;
			servo_cnt <= 27'h0000000;
			// Starts high so a timing clock already high at release is not taken as a tick
			share_q <= 1'b1;
			// Open-drain line: only ever driven low, the enable decides
			output_run_pin_out <= 1'b0;
			output_run_pin_oe <= 1'b1;
			discontinuous <= 1'b1;
			bottom_gate_en <= 1'b0;
			servo_active <= 1'b0;
			ramping <= 1'b0;
			power_good_pin <= 1'b0;
		end else begin
			state <= next_state;
			tick_cnt <= next_tick_cnt;
			step_cnt <= next_step_cnt;
			dac_code <= next_dac_code;
			servo_cnt <= next_servo_cnt;
			share_q <= share_clk;
			output_run_pin_out <= 1'b0;
			output_run_pin_oe <= next_oe;
			discontinuous <= next_disc;
			bottom_gate_en <= next_bottom;
			servo_active <= next_servo;
			ramping <= next_ramping;
			power_good_pin <= pg_filt;
		end
	end

	glitch_filter #(
		.FILTER_CYC(PG_CYCLES)
	) u_pg_filter (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.din(sense.pg_raw),
		.dout(pg_filt)
	);

	sequence run_released_s;
		state == ST_HOLD && !output_run_pin_oe;
	endsequence

	// Nonzero limit set and a fault still stands, with a real fault response
	sequence limit_blocked_s;
		state == ST_WAIT_MAX && cfg.max_turn_on_time_limit != 16'h0000 &&
			cfg.max_turn_on_time_response != RESP_IGNORE &&
			(sense.output_undervoltage_fault || sense.output_overcurrent_fault);
	endsequence

	// Ignore response: below the UV limit while the overcurrent is still active
	sequence ignore_blocked_s;
		state == ST_WAIT_MAX && cfg.max_turn_on_time_limit != 16'h0000 &&
			cfg.max_turn_on_time_response == RESP_IGNORE &&
			!sense.output_above_uv && sense.output_overcurrent_fault;
	endsequence

	run_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		!sense.init_done |=> output_run_pin_oe) else $error("run line released before init");
	shared_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state == ST_HOLD && !output_run_pin_in) |=> state == ST_HOLD || !sense.init_done)
		else $error("left hold while run line low");
	delay_wait_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state == ST_DELAY && tick_cnt < cfg.turn_on_delay_setting) |=> state inside {ST_DELAY, ST_HOLD})
		else $error("ramp started before delay");
	ramp_disc_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		$past(state) == ST_RISE |-> discontinuous) else $error("continuous mode during ramp");
	gate_rev_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(discontinuous && sense.reverse_current && state != ST_RUN) |=> !bottom_gate_en || !$past(discontinuous))
		else $error("bottom gate on with reverse current");
	servo_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		!cfg.switching_mode_config[MODE_SERVO_BIT] |=> !servo_active) else $error("servo active while disabled");
	skip_ramp_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state == ST_DELAY && next_state == ST_WAIT_MAX) |=> dac_code == $past(setpoint))
		else $error("setpoint not applied on skip");
	ramp_start_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state == ST_DELAY && next_state == ST_RISE) |=> dac_code == '0) else $error("ramp not from zero");
	run_start_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		run_released_s ##0 (sense.init_done && sense.input_above_on) |=> !output_run_pin_oe)
		else $error("run line regrabbed while ready");
	servo_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		limit_blocked_s |=> state != ST_RUN) else $error("servo started with a fault present");
	ignore_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		ignore_blocked_s |=> state != ST_RUN) else $error("servo started below UV with overcurrent");
endmodule : output_ramp_sequencer

/* testbench/peer_ctrl.sv */
// Partner controller that shares the run line and the timing clock.
// Assumes the bench resolves the run wire with a pull-up.
`timescale 1ns/100ps
module peer_ctrl (
	// Control
	input wire logic ready,
	// Shared lines
	output logic share_clk,
	output logic run_oe
);
	// Runs free and slower than ours, so it sets the common time base
	initial begin
		share_clk = 1'b0;
		// Offset keeps its edges clear of the sampling edge of clk_sys
		#2;
		forever #20 share_clk = ~share_clk;
	end
	// Holds the run line low until its own start-up is done
	assign run_oe = !ready;
endmodule : peer_ctrl

/* testbench/tb_top.sv */
// Self-checking bench for the output ramp sequencer.
// Assumes the peer model supplies the timing clock and shares the run line.
`timescale 1ns/100ps
module tb_top;
	import ramp_seq_pkg::*;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic peer_ready = 1'b0;
	logic share_clk, peer_oe, run_oe, run_out, ramping, discontinuous, bottom_gate_en, servo_active, power_good_pin;
	seq_cfg_t cfg = '0;
	seq_sense_t sense = '0;
	logic [11:0] setpoint = 12'h080;
	logic [11:0] adc_reading = 12'h080;
	logic [11:0] dac_code;
	int err_total = 0;
	int checks = 0;
	int tick_cnt = 0;
	int t0;
	// Open-drain run wire: pull-up unless someone drives it low
	wire run_wire = !(run_oe | peer_oe);
	always #4 clk_sys = ~clk_sys;
	always @(posedge share_clk) tick_cnt++;
	peer_ctrl u_peer (.ready(peer_ready), .share_clk(share_clk), .run_oe(peer_oe));
	output_ramp_sequencer #(.SERVO_CYCLES(20), .PG_CYCLES(4)) u_dut (.clk_sys(clk_sys), .rstn(rstn), .cfg(cfg),
		.sense(sense), .setpoint(setpoint), .adc_reading(adc_reading), .share_clk(share_clk),
		.output_run_pin_in(run_wire), .output_run_pin_out(run_out), .output_run_pin_oe(run_oe), .dac_code(dac_code),
		.discontinuous(discontinuous), .bottom_gate_en(bottom_gate_en), .servo_active(servo_active),
		.power_good_pin(power_good_pin), .ramping(ramping));
	task chk(string name, logic [15:0] exp, logic [15:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task cyc(int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	task complete_run();
		if (err_total == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run
	// Reset, then bring the run line up in the awkward order: vin late, peer last
	task bring_up(logic [15:0] rise, logic [7:0] mode, logic [15:0] lim, logic [7:0] resp);
		rstn <= 1'b0;
		sense <= '0;
		peer_ready <= 1'b0;
		// The peer is taken to hold the same delay and rise programming
		cfg <= '{16'h0004, rise, lim, resp, mode};
		cyc(6);
		rstn <= 1'b1;
		sense.init_done <= 1'b1;
		cyc(4);
		chk("run_oe", 1, run_oe);
		chk("run_out", 0, run_out);
		sense.input_above_on <= 1'b1;
		sense.output_above_uv <= 1'b1;
		cyc(4);
		chk("run_oe", 0, run_oe);
		cyc(60);
		chk("ramping_held", 0, ramping);
		peer_ready <= 1'b1;
		@(posedge run_wire);
		t0 = tick_cnt;
	endtask : bring_up
	task s_ramp();
		int n, bad;
		logic [11:0] prev;
		n = 0;
		bad = 0;
		prev = '0;
		adc_reading <= 12'h07E;
		bring_up(16'h0003, 8'h00, 16'h0000, RESP_IGNORE);
		while (ramping !== 1'b1 && n < 400) begin
			cyc(1);
			n++;
		end
		chk("delay_ok", 1, (tick_cnt - t0) >= 3 && (tick_cnt - t0) <= 5);
		t0 = tick_cnt;
		sense.reverse_current <= 1'b1;
		cyc(3);
		chk("bottom_gate_en", 0, bottom_gate_en);
		sense.reverse_current <= 1'b0;
		while (ramping === 1'b1 && n < 2000) begin
			if (dac_code < prev || dac_code > setpoint || discontinuous !== 1'b1) bad++;
			prev = dac_code;
			cyc(1);
			n++;
		end
		chk("ramp_ticks", 1, (tick_cnt - t0) >= 29 && (tick_cnt - t0) <= 31);
		chk("ramp_shape", 0, bad[15:0]);
		cyc(60);
		chk("dac_final", {4'h0, setpoint}, {4'h0, dac_code});
		chk("servo_off", 0, servo_active);
		chk("mode_dcm", 1, discontinuous);
	endtask : s_ramp
	task s_servo();
		int n, saw;
		logic [11:0] v;
		n = 0;
		saw = 0;
		// This loop and s_limit run the servo; the peer leaves its own off
		bring_up(16'h0002, 8'h41, 16'h0000, RESP_IGNORE);
		while (servo_active !== 1'b1 && n < 400) begin
			if (ramping === 1'b1) saw++;
			cyc(1);
			n++;
		end
		chk("ramp_skipped", 0, saw[15:0]);
		chk("dac_direct", {4'h0, setpoint}, {4'h0, dac_code});
		chk("mode_ccm", 0, discontinuous);
		cyc(25);
		chk("servo_step", 16'h0081, {4'h0, dac_code});
		adc_reading <= setpoint;
		cyc(2);
		v = dac_code;
		cyc(45);
		chk("servo_hold", {4'h0, v}, {4'h0, dac_code});
		sense.pg_raw <= 1'b1;
		cyc(2);
		sense.pg_raw <= 1'b0;
		cyc(8);
		chk("pg_glitch", 0, power_good_pin);
		sense.pg_raw <= 1'b1;
		cyc(12);
		chk("pg_steady", 1, power_good_pin);
	endtask : s_servo
	// Nonzero turn-on limit: a standing fault holds back the servo and the mode switch
	task s_limit(logic [7:0] resp);
		bring_up(16'h0002, 8'h41, 16'h0006, resp);
		sense.output_overcurrent_fault <= 1'b1;
		// Above UV would release the ignore case, so it is dropped there only
		sense.output_above_uv <= (resp != RESP_IGNORE);
		cyc(100);
		chk("servo_blocked", 0, servo_active);
		chk("disc_blocked", 1, discontinuous);
		sense.output_overcurrent_fault <= 1'b0;
		cyc(4);
		chk("servo_started", 1, servo_active);
		chk("mode_switched", 0, discontinuous);
	endtask : s_limit
	initial begin
		s_ramp();
		s_servo();
		s_limit(RESP_IGNORE);
		s_limit(8'h80);
		complete_run();
	end
	// All four scenarios need well under 10,000 cycles
	initial begin
		#200000;
		err_total++;
		complete_run();
	end
endmodule : tb_top
